// *** shared/rdw_pkg.sv ***
// Constants and types shared by the dual-watch and transmit controller
package rdw_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int HZ_PER_MHZ = 1_000_000;
	localparam int US_PER_MS = 1000;
	localparam int MS_PER_S = 1000;
	localparam int S_PER_MIN = 60;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC_DEF = CLK_HZ / HZ_PER_MHZ * TICK_US;
	localparam int PRE_W = 15;
	localparam int TMR_W = 17;
	// Durations in their own units
	localparam int SCAN_HZ = 5;
	localparam int SCAN_MS = MS_PER_S / (2 * SCAN_HZ);
	localparam int STB_HOLD_S = 2;
	localparam int PEEK_MS = 300;
	localparam int TX_TO_MIN = 2;
	localparam int LOCK_S = 2;
	localparam int ERR_S = 5;
	localparam int LINK_MIN = 1;
	// Durations in ticks
	localparam logic [TMR_W-1:0] DWELL_TK = TMR_W'(SCAN_MS * US_PER_MS / TICK_US);
	localparam logic [TMR_W-1:0] STB_HOLD_TK = TMR_W'(STB_HOLD_S * MS_PER_S * US_PER_MS / TICK_US);
	localparam logic [TMR_W-1:0] PEEK_TK = TMR_W'(PEEK_MS * US_PER_MS / TICK_US);
	localparam logic [TMR_W-1:0] TX_TO_TK =
		TMR_W'(TX_TO_MIN * S_PER_MIN * MS_PER_S * US_PER_MS / TICK_US);
	localparam logic [TMR_W-1:0] LOCK_TK = TMR_W'(LOCK_S * MS_PER_S * US_PER_MS / TICK_US);
	localparam logic [TMR_W-1:0] ERR_TK = TMR_W'(ERR_S * MS_PER_S * US_PER_MS / TICK_US);
	localparam logic [TMR_W-1:0] LINK_TK =
		TMR_W'(LINK_MIN * S_PER_MIN * MS_PER_S * US_PER_MS / TICK_US);
	// Register word indexes
	localparam logic [2:0] REG_CFG = 3'h0;
	localparam logic [2:0] REG_MIC = 3'h1;
	localparam logic [2:0] REG_LVL = 3'h2;
	localparam logic [2:0] REG_STAT = 3'h3;
	localparam logic [2:0] REG_GAIN = 3'h4;
	// Field positions
	localparam int CFG_SEL_LO = 0;
	localparam int CFG_IMP_BIT = 2;
	localparam int MIC_L_LO = 0;
	localparam int MIC_R_LO = 4;
	localparam int LVL_VOL_LO = 0;
	localparam int LVL_NG_LO = 8;
	localparam int LVL_VT_LO = 12;
	localparam int SEL_L = 0;
	localparam int SEL_R = 1;
	localparam int K_WATCH = 0;
	localparam int K_TUNE = 1;
	localparam int K_STORE = 2;
	localparam int K_SOUND = 3;
	// Values
	localparam logic [3:0] GAIN_MIN = 4'h1;
	localparam logic [3:0] GAIN_DYN = 4'hB;
	localparam logic [3:0] VT_OFF = 4'hA;
	localparam logic [15:0] LOW_SUPPLY_MV = 16'h2904;
	localparam logic [1:0] RST_SEL = 2'h3;
	localparam logic [3:0] RST_GAIN = 4'h5;
	localparam logic [4:0] RST_VOL = 5'h0A;
	localparam logic [3:0] RST_NG = 4'h3;
	localparam logic [3:0] RST_VT = 4'hA;
	localparam logic [2:0] ERR_NONE = 3'h0;
	localparam logic [2:0] ERR_LAST = 3'h5;
	typedef enum logic [1:0] {SC_ACT = 2'b01, SC_STB = 2'b10} rdw_scan_t;
	localparam int SC_STB_IDX = 1;
	typedef enum logic [3:0] {
		PW_SAMPLE = 4'b0001,
		PW_DEFAULT = 4'b0010,
		PW_SETUP = 4'b0100,
		PW_RUN = 4'b1000
	} rdw_pw_t;
	localparam int PW_SETUP_IDX = 2;
endpackage : rdw_pkg

// *** design/rdw_top.sv ***
// Dual-watch scanning, transmit gating and panel control for the transceiver
// Function
// - Watch key toggles dual-watch; tuning or store key ends it.
// - Idle dual-watch alternates channels, both covered five times a second.
// - Reception on active channel holds receiver there until it ends.
// - Standby reception peeks active channel 0.3 s every 2 s.
// - Dual-watch shows indication and pointer to receiving channel.
// - Transmit only on active channel while talk held; show tx/rx.
// - Two minutes keyed cuts transmitter and shows timeout flag.
// - After timeout, re-key needs release and new press.
// - Transmit disables external audio, enables selected mic, sidetone to headset.
// - Speaker muted while transmitting or intercom active.
// - Sound and tuning keys held over 2 s toggle lock.
// - Lock blocks talk select through mic setup; levels stay adjustable.
// - Mic gain accepts 1 to 11; 10 electret, 11 dynamic.
// - Mic settings committed only on leaving mic setup.
// - Detect mode measures left only; dynamic forces left 11, restores later.
// - Dynamic mic after transmit forces voice trigger 10, shows symbol.
// - Low supply below 10.5 V; antenna mismatch while transmitting.
// - Store and watch at power-up: prompt, reset on release, done.
// - Store alone at power-up enters setup; store press exits.
// - Remote errors shown as five codes, cleared by command, entry, 5 s.
// - Link checked each minute, good indicator; errors leave radio alone.
module rdw_top #(
	parameter int unsigned P_TICK_CYC = rdw_pkg::TICK_CYC_DEF
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Avalon-MM slave
	input wire logic [2:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Panel keys and talk switches
	input wire logic i_key_watch,
	input wire logic i_key_tune,
	input wire logic i_key_store,
	input wire logic i_key_sound,
	input wire logic i_talk_l,
	input wire logic i_talk_r,
	// Receiver, audio and monitors
	input wire logic i_carrier,
	input wire logic i_intercom_active,
	input wire logic [15:0] i_supply_mv,
	input wire logic i_ant_bad,
	input wire logic i_imp_dynamic_l,
	input wire logic i_mic_menu_exit,
	// Remote link
	input wire logic i_remote_err,
	input wire logic [2:0] i_remote_err_code,
	input wire logic i_remote_valid,
	input wire logic i_freq_entry,
	input wire logic i_link_reply,
	// Radio control
	output logic o_tx_key,
	output logic o_rx_standby,
	output logic o_ext_audio_en,
	output logic o_mic_l_en,
	output logic o_mic_r_en,
	output logic o_headset_sidetone,
	output logic o_spk_mute,
	output logic [3:0] o_gain_l,
	output logic [3:0] o_gain_r,
	output logic [3:0] o_voice_trigger_level,
	output logic [3:0] o_noise_gate_level,
	output logic [4:0] o_volume,
	output logic o_mic_store,
	// Indications
	output logic o_ind_tx,
	output logic o_ind_rx,
	output logic o_transmit_timeout_flag,
	output logic o_ind_dual,
	output logic o_ptr_standby,
	output logic o_ind_lock,
	output logic o_low_supply_warning,
	output logic o_ant_mismatch,
	output logic o_dyn_mic_symbol,
	output logic [2:0] o_err_code,
	output logic o_link_good,
	output logic o_link_probe,
	// Power-up functions
	output logic o_defaults_prompt,
	output logic o_defaults_done,
	output logic o_factory_reset,
	output logic o_setup_active,
	output logic o_favs_erase,
	output logic o_spacing_833
);
	localparam int PRE_W = rdw_pkg::PRE_W;
	localparam int TMR_W = rdw_pkg::TMR_W;
	localparam logic [PRE_W-1:0] TICK_END = PRE_W'(P_TICK_CYC - 1);

	typedef struct packed {
		rdw_pkg::rdw_pw_t pw;
		rdw_pkg::rdw_scan_t scan;
		logic [PRE_W-1:0] pre;
		logic tick;
		logic [TMR_W-1:0] scan_t;
		logic [TMR_W-1:0] tx_t;
		logic [TMR_W-1:0] lock_t;
		logic [TMR_W-1:0] err_t;
		logic [TMR_W-1:0] link_t;
		logic [3:0] kp;
		logic dual;
		logic peek;
		logic ptr_stb;
		logic tx_key;
		logic te;
		logic rx_ind;
		logic lock;
		logic lock_hold;
		logic spk_mute;
		logic ext_en;
		logic mic_l;
		logic mic_r;
		logic side;
		logic low_sup;
		logic ant_bad;
		logic imp;
		logic dyn;
		logic [1:0] sel;
		logic [3:0] stg_l;
		logic [3:0] stg_r;
		logic [3:0] sav_l;
		logic [3:0] sav_r;
		logic [3:0] out_l;
		logic [3:0] out_r;
		logic [3:0] vt_out;
		logic [4:0] vol;
		logic [3:0] ng;
		logic [3:0] vt;
		logic store_p;
		logic [2:0] err;
		logic link_seen;
		logic link_good;
		logic probe;
		logic prompt;
		logic done;
		logic fac;
		logic setup_arm;
		logic erase;
		logic s833;
		logic ack;
		logic wreq;
		logic [31:0] rdata;
	} rdw_state_t;

	rdw_state_t st;
	rdw_state_t next_st;
	logic [3:0] keys;
	logic [3:0] press;
	logic talk;
	logic run;
	logic tx_req;
	logic to_now;
	logic [31:0] wnew;

	// Saturating tick timer
	function automatic logic [TMR_W-1:0] tmr_inc(input logic [TMR_W-1:0] t, input logic en);
		return (en && t != '1) ? TMR_W'(t + 1'b1) : t;
	endfunction : tmr_inc

	function automatic logic gain_ok(input logic [3:0] g);
		return g >= rdw_pkg::GAIN_MIN && g <= rdw_pkg::GAIN_DYN;
	endfunction : gain_ok

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction : be_merge

	assign keys = {i_key_sound, i_key_store, i_key_tune, i_key_watch};
	assign press = keys & ~st.kp;
	assign run = st.pw == rdw_pkg::PW_RUN;
	assign talk = (i_talk_l & st.sel[rdw_pkg::SEL_L]) | (i_talk_r & st.sel[rdw_pkg::SEL_R]);
	assign tx_req = run & talk & ~st.te;
	assign to_now = st.tx_key && st.tx_t >= rdw_pkg::TX_TO_TK;

	always_comb
	begin
		next_st = st;
		wnew = '0;
		next_st.kp = keys;
		next_st.fac = 1'b0;
		next_st.erase = 1'b0;
		next_st.store_p = 1'b0;
		next_st.probe = 1'b0;
		// One shared millisecond tick; all timers count it
		next_st.tick = 1'b0;
		if (st.pre == TICK_END)
		begin
			next_st.pre = '0;
			next_st.tick = 1'b1;
		end
		else
			next_st.pre = PRE_W'(st.pre + 1'b1);

		// Power-up key straps, caught after reset release
		unique case (st.pw)
			rdw_pkg::PW_SAMPLE:
			begin
				if (keys[rdw_pkg::K_STORE] && keys[rdw_pkg::K_WATCH])
				begin
					next_st.pw = rdw_pkg::PW_DEFAULT;
					next_st.prompt = 1'b1;
				end
				else if (keys[rdw_pkg::K_STORE])
					next_st.pw = rdw_pkg::PW_SETUP;
				else
					next_st.pw = rdw_pkg::PW_RUN;
			end
			rdw_pkg::PW_DEFAULT:
			begin
				if (!keys[rdw_pkg::K_STORE] && !keys[rdw_pkg::K_WATCH])
				begin
					next_st.prompt = 1'b0;
					next_st.fac = 1'b1;
					next_st.done = 1'b1;
					next_st.pw = rdw_pkg::PW_RUN;
				end
			end
			rdw_pkg::PW_SETUP:
			begin
				// The store key that entered setup must be let go first
				if (!keys[rdw_pkg::K_STORE])
					next_st.setup_arm = 1'b1;
				if (st.setup_arm && press[rdw_pkg::K_STORE])
					next_st.pw = rdw_pkg::PW_RUN;
				if (press[rdw_pkg::K_WATCH])
					next_st.erase = 1'b1;
				if (press[rdw_pkg::K_TUNE])
					next_st.s833 = ~st.s833;
			end
			rdw_pkg::PW_RUN:
			begin
				if (|press)
					next_st.done = 1'b0;
			end
		endcase

		// Dual-watch on/off
		if (run)
		begin
			if (press[rdw_pkg::K_TUNE] || press[rdw_pkg::K_STORE])
				next_st.dual = 1'b0;
			else if (press[rdw_pkg::K_WATCH])
				next_st.dual = ~st.dual;
		end

		// Menu lock by long two-key hold
		if (run && keys[rdw_pkg::K_SOUND] && keys[rdw_pkg::K_TUNE])
		begin
			next_st.lock_t = tmr_inc(st.lock_t, st.tick);
			if (!st.lock_hold && st.lock_t > rdw_pkg::LOCK_TK)
			begin
				next_st.lock = ~st.lock;
				next_st.lock_hold = 1'b1;
			end
		end
		else
		begin
			next_st.lock_t = '0;
			next_st.lock_hold = 1'b0;
		end

		// Channel scanning; a talk request pins the receiver to active
		next_st.scan_t = tmr_inc(st.scan_t, st.tick);
		if (!st.dual || tx_req)
		begin
			next_st.scan = rdw_pkg::SC_ACT;
			next_st.peek = 1'b0;
			next_st.scan_t = '0;
		end
		else
		begin
			unique case (st.scan)
				rdw_pkg::SC_ACT:
				begin
					if (i_carrier)
					begin
						next_st.peek = 1'b0;
						next_st.scan_t = '0;
					end
					else if (st.peek ? st.scan_t >= rdw_pkg::PEEK_TK
							: st.scan_t >= rdw_pkg::DWELL_TK)
					begin
						next_st.scan = rdw_pkg::SC_STB;
						next_st.peek = 1'b0;
						next_st.scan_t = '0;
					end
				end
				rdw_pkg::SC_STB:
				begin
					if (i_carrier && st.scan_t >= rdw_pkg::STB_HOLD_TK)
					begin
						next_st.scan = rdw_pkg::SC_ACT;
						next_st.peek = 1'b1;
						next_st.scan_t = '0;
					end
					else if (!i_carrier && st.scan_t >= rdw_pkg::DWELL_TK)
					begin
						next_st.scan = rdw_pkg::SC_ACT;
						next_st.scan_t = '0;
					end
				end
			endcase
		end
		if (st.dual && i_carrier)
			next_st.ptr_stb = st.scan == rdw_pkg::SC_STB;

		// Transmit gating and stuck-switch timeout
		next_st.tx_key = tx_req && st.scan == rdw_pkg::SC_ACT && !to_now;
		next_st.tx_t = st.tx_key ? tmr_inc(st.tx_t, st.tick) : '0;
		if (!talk)
			next_st.te = 1'b0;
		else if (to_now)
			next_st.te = 1'b1;
		next_st.rx_ind = ~next_st.tx_key;
		next_st.ext_en = ~next_st.tx_key;
		next_st.mic_l = next_st.tx_key & i_talk_l & st.sel[rdw_pkg::SEL_L];
		next_st.mic_r = next_st.tx_key & i_talk_r & st.sel[rdw_pkg::SEL_R];
		next_st.side = next_st.tx_key;
		next_st.spk_mute = next_st.tx_key | i_intercom_active;

		// Self-test warnings
		next_st.low_sup = i_supply_mv < rdw_pkg::LOW_SUPPLY_MV;
		next_st.ant_bad = next_st.tx_key & i_ant_bad;

		// Remote link errors; a new error wins over a clear
		next_st.err_t = tmr_inc(st.err_t, st.tick);
		if (i_remote_err && i_remote_err_code != rdw_pkg::ERR_NONE
				&& i_remote_err_code <= rdw_pkg::ERR_LAST)
		begin
			next_st.err = i_remote_err_code;
			next_st.err_t = '0;
		end
		else if (i_remote_valid || i_freq_entry || st.err_t >= rdw_pkg::ERR_TK)
			next_st.err = rdw_pkg::ERR_NONE;

		// Link supervision once a minute
		next_st.link_t = tmr_inc(st.link_t, st.tick);
		if (i_link_reply)
			next_st.link_seen = 1'b1;
		if (st.link_t >= rdw_pkg::LINK_TK)
		begin
			next_st.link_t = '0;
			next_st.probe = 1'b1;
			next_st.link_good = st.link_seen | i_link_reply;
			next_st.link_seen = i_link_reply;
		end

		// Bus slave: one wait cycle, then the access completes
		next_st.ack = (i_avs_read | i_avs_write) & ~st.ack;
		next_st.wreq = ~next_st.ack;
		if (i_avs_read && !st.ack)
		begin
			unique case (i_avs_address)
				rdw_pkg::REG_CFG: next_st.rdata = 32'({st.imp, st.sel});
				rdw_pkg::REG_MIC: next_st.rdata = 32'({st.stg_r, st.stg_l});
				rdw_pkg::REG_LVL: next_st.rdata = 32'({st.vt, st.ng, 3'h0, st.vol});
				rdw_pkg::REG_STAT: next_st.rdata = 32'({st.err, st.link_good, st.s833,
					st.pw[rdw_pkg::PW_SETUP_IDX], st.dyn, st.ant_bad, st.low_sup,
					st.lock, st.te, st.tx_key, st.ptr_stb,
					st.scan[rdw_pkg::SC_STB_IDX], st.dual});
				rdw_pkg::REG_GAIN: next_st.rdata = 32'({st.vt_out, st.out_r, st.out_l,
					st.sav_r, st.sav_l});
				default: next_st.rdata = '0;
			endcase
		end
		if (i_avs_write && st.ack)
		begin
			unique case (i_avs_address)
				rdw_pkg::REG_CFG:
				begin
					wnew = be_merge(32'({st.imp, st.sel}), i_avs_writedata, i_avs_byteenable);
					if (!st.lock)
					begin
						next_st.sel = wnew[rdw_pkg::CFG_SEL_LO +: 2];
						next_st.imp = wnew[rdw_pkg::CFG_IMP_BIT];
					end
				end
				rdw_pkg::REG_MIC:
				begin
					wnew = be_merge(32'({st.stg_r, st.stg_l}), i_avs_writedata, i_avs_byteenable);
					if (!st.lock && gain_ok(wnew[rdw_pkg::MIC_L_LO +: 4]))
						next_st.stg_l = wnew[rdw_pkg::MIC_L_LO +: 4];
					if (!st.lock && gain_ok(wnew[rdw_pkg::MIC_R_LO +: 4]))
						next_st.stg_r = wnew[rdw_pkg::MIC_R_LO +: 4];
				end
				rdw_pkg::REG_LVL:
				begin
					wnew = be_merge(32'({st.vt, st.ng, 3'h0, st.vol}), i_avs_writedata,
						i_avs_byteenable);
					next_st.vol = wnew[rdw_pkg::LVL_VOL_LO +: 5];
					next_st.ng = wnew[rdw_pkg::LVL_NG_LO +: 4];
					next_st.vt = wnew[rdw_pkg::LVL_VT_LO +: 4];
				end
				default: wnew = '0;
			endcase
		end

		// Mic commit on setup exit; staging alone changes nothing
		if (i_mic_menu_exit)
		begin
			next_st.sav_l = st.stg_l;
			next_st.sav_r = st.stg_r;
			next_st.store_p = 1'b1;
		end
		if (!st.imp)
			next_st.dyn = 1'b0;
		else if (st.tx_key && !next_st.tx_key)
			next_st.dyn = i_imp_dynamic_l;
		next_st.out_l = next_st.dyn ? rdw_pkg::GAIN_DYN : next_st.sav_l;
		next_st.out_r = next_st.sav_r;
		next_st.vt_out = next_st.dyn ? rdw_pkg::VT_OFF : next_st.vt;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st <= '0;
			st.pw <= rdw_pkg::PW_SAMPLE;
			st.scan <= rdw_pkg::SC_ACT;
			st.sel <= rdw_pkg::RST_SEL;
			st.stg_l <= rdw_pkg::RST_GAIN;
			st.stg_r <= rdw_pkg::RST_GAIN;
			st.sav_l <= rdw_pkg::RST_GAIN;
			st.sav_r <= rdw_pkg::RST_GAIN;
			st.out_l <= rdw_pkg::RST_GAIN;
			st.out_r <= rdw_pkg::RST_GAIN;
			st.vol <= rdw_pkg::RST_VOL;
			st.ng <= rdw_pkg::RST_NG;
			st.vt <= rdw_pkg::RST_VT;
			st.vt_out <= rdw_pkg::RST_VT;
			st.rx_ind <= 1'b1;
			st.ext_en <= 1'b1;
			st.wreq <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign o_avs_readdata = st.rdata;
	assign o_avs_waitrequest = st.wreq;
	assign o_tx_key = st.tx_key;
	assign o_rx_standby = st.scan[rdw_pkg::SC_STB_IDX];
	assign o_ext_audio_en = st.ext_en;
	assign o_mic_l_en = st.mic_l;
	assign o_mic_r_en = st.mic_r;
	assign o_headset_sidetone = st.side;
	assign o_spk_mute = st.spk_mute;
	assign o_gain_l = st.out_l;
	assign o_gain_r = st.out_r;
	assign o_voice_trigger_level = st.vt_out;
	assign o_noise_gate_level = st.ng;
	assign o_volume = st.vol;
	assign o_mic_store = st.store_p;
	assign o_ind_tx = st.tx_key;
	assign o_ind_rx = st.rx_ind;
	assign o_transmit_timeout_flag = st.te;
	assign o_ind_dual = st.dual;
	assign o_ptr_standby = st.ptr_stb;
	assign o_ind_lock = st.lock;
	assign o_low_supply_warning = st.low_sup;
	assign o_ant_mismatch = st.ant_bad;
	assign o_dyn_mic_symbol = st.dyn;
	assign o_err_code = st.err;
	assign o_link_good = st.link_good;
	assign o_link_probe = st.probe;
	assign o_defaults_prompt = st.prompt;
	assign o_defaults_done = st.done;
	assign o_factory_reset = st.fac;
	assign o_setup_active = st.pw[rdw_pkg::PW_SETUP_IDX];
	assign o_favs_erase = st.erase;
	assign o_spacing_833 = st.s833;

	AST_WATCH_TOGGLE: assert property (@(posedge i_clk) disable iff (i_rst)
		(run && press[rdw_pkg::K_WATCH] && !press[rdw_pkg::K_TUNE] && !press[rdw_pkg::K_STORE])
		|=> st.dual != $past(st.dual)) else $error("watch key did not toggle");
	AST_ACT_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		(st.scan == rdw_pkg::SC_ACT && i_carrier) |=> st.scan == rdw_pkg::SC_ACT)
		else $error("left active channel during reception");
	AST_PEEK_BACK: assert property (@(posedge i_clk) disable iff (i_rst)
		(st.dual && !tx_req && st.scan == rdw_pkg::SC_ACT && st.peek && !i_carrier
		&& st.scan_t >= rdw_pkg::PEEK_TK) |=> st.scan == rdw_pkg::SC_STB)
		else $error("peek did not return to standby");
	AST_TX_ACTIVE: assert property (@(posedge i_clk) disable iff (i_rst)
		st.tx_key |-> (st.scan == rdw_pkg::SC_ACT && $past(talk)))
		else $error("keyed off active channel or without talk");
	AST_TO_CUT: assert property (@(posedge i_clk) disable iff (i_rst)
		to_now && talk |=> st.te && !st.tx_key) else $error("timeout did not cut transmitter");
	AST_NO_REKEY: assert property (@(posedge i_clk) disable iff (i_rst)
		st.te && talk |=> st.te && !st.tx_key) else $error("held switch re-keyed");
	AST_SPK_MUTE: assert property (@(posedge i_clk) disable iff (i_rst)
		(st.tx_key || $past(i_intercom_active)) |-> st.spk_mute) else $error("speaker not muted");
	AST_EXT_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
		st.tx_key |-> !st.ext_en && st.side) else $error("audio routing wrong in transmit");
	AST_MIC_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_mic_menu_exit |=> $stable(st.sav_l) && $stable(st.sav_r))
		else $error("mic settings committed early");
	AST_LOW_SUP: assert property (@(posedge i_clk) disable iff (i_rst)
		i_supply_mv < rdw_pkg::LOW_SUPPLY_MV |=> st.low_sup) else $error("low supply missed");
	AST_ERR_CLR: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_remote_valid && !i_remote_err) |=> st.err == rdw_pkg::ERR_NONE)
		else $error("remote error not cleared");
endmodule : rdw_top

// *** bench/rdw_panel_model.sv ***
// Pilot panel model: front keys and talk switches
module rdw_panel_model (
	// Clock
	input wire logic i_clk,
	// Key and talk levels
	output logic o_watch,
	output logic o_tune,
	output logic o_store,
	output logic o_sound,
	output logic o_talk_l,
	output logic o_talk_r
);
	// All released at power-up so no strap mode is entered
	initial {o_sound, o_store, o_tune, o_watch, o_talk_r, o_talk_l} = 6'h00;
	// Levels move only after an edge; each call drives all six levels at once, with no release inserted before a press
	task automatic set(input logic [5:0] v);
		@(posedge i_clk);
		{o_sound, o_store, o_tune, o_watch, o_talk_r, o_talk_l} <= v;
	endtask : set
endmodule : rdw_panel_model

// *** bench/rdw_top_test.sv ***
// Self-checking bench for the dual-watch and transmit controller
module rdw_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 2;
	logic i_clk, i_rst, i_avs_read, i_avs_write, i_carrier, i_intercom_active, i_ant_bad;
	logic [2:0] i_avs_address, i_remote_err_code;
	logic [31:0] i_avs_writedata, o_avs_readdata, q;
	logic [15:0] i_supply_mv;
	logic i_imp_dynamic_l, i_mic_menu_exit, i_remote_err, i_remote_valid, i_freq_entry;
	logic i_link_reply, i_key_watch, i_key_tune, i_key_store, i_key_sound, i_talk_l, i_talk_r;
	logic [3:0] i_avs_byteenable, o_gain_l, o_gain_r, o_voice_trigger_level, o_noise_gate_level;
	logic [4:0] o_volume;
	logic [2:0] o_err_code;
	logic o_avs_waitrequest, o_tx_key, o_rx_standby, o_ext_audio_en, o_mic_l_en, o_mic_r_en;
	logic o_headset_sidetone, o_spk_mute, o_mic_store, o_ind_tx, o_ind_rx, o_transmit_timeout_flag;
	logic o_ind_dual, o_ptr_standby, o_ind_lock, o_low_supply_warning, o_ant_mismatch;
	logic o_dyn_mic_symbol, o_link_good, o_link_probe, o_defaults_prompt, o_defaults_done;
	logic o_factory_reset, o_setup_active, o_favs_erase, o_spacing_833;
	int err_total = 0;
	int checks_done = 0;
	rdw_top #(.P_TICK_CYC(TK)) rdw_top_inst (.*);
	rdw_panel_model rdw_panel_model_inst (.i_clk(i_clk), .o_watch(i_key_watch),
		.o_tune(i_key_tune), .o_store(i_key_store), .o_sound(i_key_sound),
		.o_talk_l(i_talk_l), .o_talk_r(i_talk_r));
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			err_total++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc
	// Holds the request until waitrequest is sampled low; bounded so a dead slave ends the run
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		int n;
		n = 0;
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= w;
		i_avs_read <= !w;
		do
		begin
			@(posedge i_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		if (n >= 50)
		begin
			err_total++;
			conclude();
		end
	endtask : bus
	task automatic t_reset();
		chk({o_ext_audio_en, o_ind_rx, o_tx_key, o_volume, o_noise_gate_level}, 32'hCA3);
		bus(1'b0, rdw_pkg::REG_GAIN, 32'h0);
		chk(q, 32'h000A5555);
		bus(1'b0, 3'h7, 32'h0);
		chk(q, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_mic();
		bus(1'b1, rdw_pkg::REG_MIC, 32'h000000CB);
		bus(1'b0, rdw_pkg::REG_GAIN, 32'h0);
		chk(q[7:0], 32'h55);
		i_mic_menu_exit <= 1'b1;
		cyc(1);
		i_mic_menu_exit <= 1'b0;
		cyc(1);
		chk(o_mic_store, 1'b1);
		cyc(2);
		chk({o_gain_l, o_gain_r}, 32'hB5);
		$display("test mic done");
	endtask : t_mic
	task automatic t_dual();
		int n;
		rdw_panel_model_inst.set(6'h04);
		rdw_panel_model_inst.set(6'h00);
		cyc(2);
		chk(o_ind_dual, 1'b1);
		n = 0;
		do begin @(posedge i_clk); n++; end while (o_rx_standby !== 1'b1 && n < 500);
		chk(o_rx_standby, 1'b1);
		n = 0;
		do begin @(posedge i_clk); n++; end while (o_rx_standby === 1'b1 && n < 500);
		chk(n, TK * rdw_pkg::DWELL_TK);
		i_carrier <= 1'b1;
		cyc(600);
		chk(o_rx_standby, 1'b0);
		i_carrier <= 1'b0;
		rdw_panel_model_inst.set(6'h08);
		rdw_panel_model_inst.set(6'h00);
		cyc(2);
		chk(o_ind_dual, 1'b0);
		$display("test dual done");
	endtask : t_dual
	task automatic t_tx();
		bus(1'b1, rdw_pkg::REG_CFG, 32'h5);
		i_ant_bad <= 1'b1;
		i_imp_dynamic_l <= 1'b1;
		rdw_panel_model_inst.set(6'h01);
		cyc(5);
		chk({o_tx_key, o_ind_tx, o_ind_rx, o_ext_audio_en}, 32'hC);
		chk({o_mic_l_en, o_mic_r_en, o_headset_sidetone, o_spk_mute}, 32'hB);
		chk(o_ant_mismatch, 1'b1);
		rdw_panel_model_inst.set(6'h02);
		cyc(5);
		chk({o_tx_key, o_ant_mismatch, o_spk_mute, o_dyn_mic_symbol}, 32'h1);
		rdw_panel_model_inst.set(6'h00);
		i_intercom_active <= 1'b1;
		cyc(3);
		chk(o_spk_mute, 1'b1);
		i_intercom_active <= 1'b0;
		$display("test tx done");
	endtask : t_tx
	// Lock takes a long two-key hold; levels must still reach through partial lanes
	task automatic t_lock();
		rdw_panel_model_inst.set(6'h28);
		cyc(TK * rdw_pkg::LOCK_TK + 10);
		chk(o_ind_lock, 1'b1);
		rdw_panel_model_inst.set(6'h00);
		bus(1'b1, rdw_pkg::REG_CFG, 32'h3);
		bus(1'b0, rdw_pkg::REG_CFG, 32'h0);
		chk(q, 32'h5);
		i_avs_byteenable <= 4'h2;
		bus(1'b1, rdw_pkg::REG_LVL, 32'h7400);
		i_avs_byteenable <= 4'hF;
		bus(1'b0, rdw_pkg::REG_LVL, 32'h0);
		chk(q, 32'h740A);
		chk({o_voice_trigger_level, o_noise_gate_level}, 32'hA4);
		$display("test lock done");
	endtask : t_lock
	task automatic t_strap();
		rdw_panel_model_inst.set(6'h14);
		i_rst <= 1'b1;
		cyc(2);
		i_rst <= 1'b0;
		cyc(2);
		chk(o_defaults_prompt, 1'b1);
		rdw_panel_model_inst.set(6'h00);
		cyc(2);
		chk({o_defaults_prompt, o_factory_reset, o_defaults_done}, 32'h3);
		rdw_panel_model_inst.set(6'h10);
		i_rst <= 1'b1;
		cyc(2);
		i_rst <= 1'b0;
		cyc(2);
		chk(o_setup_active, 1'b1);
		rdw_panel_model_inst.set(6'h00);
		rdw_panel_model_inst.set(6'h0C);
		cyc(2);
		chk({o_favs_erase, o_spacing_833, o_setup_active}, 32'h7);
		rdw_panel_model_inst.set(6'h10);
		rdw_panel_model_inst.set(6'h00);
		cyc(2);
		chk({o_setup_active, o_spacing_833}, 32'h1);
		$display("test power-up done");
	endtask : t_strap
	task automatic t_mon();
		i_supply_mv <= rdw_pkg::LOW_SUPPLY_MV;
		cyc(3);
		chk(o_low_supply_warning, 1'b0);
		i_supply_mv <= rdw_pkg::LOW_SUPPLY_MV - 16'h0001;
		cyc(3);
		chk(o_low_supply_warning, 1'b1);
		i_remote_err <= 1'b1;
		i_remote_err_code <= 3'h2;
		cyc(1);
		i_remote_err <= 1'b0;
		cyc(2);
		chk(o_err_code, 3'h2);
		i_remote_valid <= 1'b1;
		cyc(1);
		i_remote_valid <= 1'b0;
		cyc(2);
		chk(o_err_code, rdw_pkg::ERR_NONE);
		i_remote_err <= 1'b1;
		i_remote_err_code <= 3'h4;
		cyc(1);
		i_remote_err <= 1'b0;
		i_freq_entry <= 1'b1;
		cyc(1);
		i_freq_entry <= 1'b0;
		chk(o_err_code, 3'h4);
		cyc(2);
		chk(o_err_code, rdw_pkg::ERR_NONE);
		$display("test monitors done");
	endtask : t_mon
	initial
	begin
		{i_avs_read, i_avs_write, i_carrier, i_intercom_active, i_ant_bad} = 5'h00;
		{i_imp_dynamic_l, i_mic_menu_exit, i_remote_err, i_remote_valid} = 4'h0;
		{i_freq_entry, i_link_reply, i_avs_address, i_remote_err_code} = 8'h00;
		i_avs_writedata = 32'h0;
		i_avs_byteenable = 4'hF;
		i_supply_mv = 16'h3000;
		i_rst = 1'b1;
		cyc(16);
		i_rst <= 1'b0;
		cyc(3);
		t_reset();
		t_mic();
		t_dual();
		t_tx();
		t_lock();
		t_mon();
		t_strap();
		conclude();
	end
endmodule : rdw_top_test
